// File: design/sync_io_pkg.sv
/*
 * constants for the two sync trigger lines of the load.
 * assumes a 40 MHz clock; all times are converted to cycles here.
 */
package sync_io_pkg;

    // ==========================================================
    // timing
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned MIN_LOW_US      = 30;
    // least time: whole cycles, no rounding up is added
    localparam int unsigned MIN_LOW_CYC     = (MIN_LOW_US * (CLK_HZ / 1_000_000) + 0) ;
    // emitted pulse is held low a little longer than the receiver needs
    localparam int unsigned TX_PULSE_US     = 40;
    localparam int unsigned TX_PULSE_CYC    = TX_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int unsigned CNT_W           = 12;

    // ==========================================================
    // register map (word addresses on the plain port)
    localparam logic [3:0] ADDR_ON_CFG      = 4'h0;
    localparam logic [3:0] ADDR_OFF_CFG     = 4'h1;
    localparam logic [3:0] ADDR_ON_PWM_PER  = 4'h2;
    localparam logic [3:0] ADDR_ON_PWM_DUTY = 4'h3;
    localparam logic [3:0] ADDR_OFF_PWM_PER = 4'h4;
    localparam logic [3:0] ADDR_OFF_PWM_DUTY= 4'h5;
    localparam logic [3:0] ADDR_STATUS      = 4'h6;
    localparam logic [3:0] ADDR_SWITCH_CMD  = 4'h7;

    // config fields
    localparam int unsigned CFG_FUNC_LSB    = 0;
    localparam int unsigned CFG_INV_BIT     = 2;
    localparam int unsigned CFG_OUTSEL_LSB  = 3;
    localparam logic [1:0]  FUNC_SYNC       = 2'h0;
    localparam logic [1:0]  FUNC_INPUT      = 2'h1;
    localparam logic [1:0]  FUNC_OUTPUT     = 2'h2;
    localparam logic [1:0]  OUT_FALSE       = 2'h0;
    localparam logic [1:0]  OUT_TRUE        = 2'h1;
    localparam logic [1:0]  OUT_PWM         = 2'h2;
    localparam logic [4:0]  CFG_RESET       = 5'h00;
    localparam logic [15:0] PWM_PER_RESET   = 16'h9c40;
    localparam logic [15:0] PWM_DUTY_RESET  = 16'h4e20;

    // switch command bits
    localparam int unsigned CMD_ON_BIT      = 0;
    localparam int unsigned CMD_OFF_BIT     = 1;

    // status fields
    localparam int unsigned ST_SWITCH_BIT   = 0;
    localparam int unsigned ST_LVL_ON_BIT   = 1;
    localparam int unsigned ST_LVL_OFF_BIT  = 2;

endpackage

// File: design/sync_line_if.sv
/*
 * bundle between the top and one line engine.
 * assumes one clock domain, driven by the top.
 */
`timescale 1ns/1ps
`default_nettype none
interface sync_line_if;
    logic [1:0]  func;
    logic        invert;
    logic [1:0]  out_sel;
    logic [15:0] pwm_per;
    logic [15:0] pwm_duty;
    logic        tx_req;
    logic        rx_pulse;
    logic        level;

    modport ctrl (output func, invert, out_sel, pwm_per, pwm_duty, tx_req,
                  input rx_pulse, level);
    modport line (input func, invert, out_sel, pwm_per, pwm_duty, tx_req,
                  output rx_pulse, level);
endinterface
`default_nettype wire

// File: design/sync_line.sv
/*
 * one trigger line: filter, pulse sender, level reader, driver, pwm.
 * assumes pin input synchronous to ref_clk; open drain style pin.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_line (
    // clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst_n,
    // control side
    sync_line_if.line   cfg,
    // pin
    input  wire logic   pin_in,
    output logic        pin_out,
    output logic        pin_oe
);
    localparam logic [11:0] MIN_LOW = 12'(sync_io_pkg::MIN_LOW_CYC);
    localparam logic [11:0] TX_LEN  = 12'(sync_io_pkg::TX_PULSE_CYC);

    logic        sync1_reg, sync2_reg, sync1_next, sync2_next;
    logic [11:0] low_cnt_reg, low_cnt_next;
    logic        seen_reg, seen_next;
    logic        rx_reg, rx_next;
    logic        lvl_reg, lvl_next;
    logic [11:0] tx_cnt_reg, tx_cnt_next;
    logic [15:0] pwm_cnt_reg, pwm_cnt_next;
    logic        out_reg, out_next;
    logic        oe_reg, oe_next;
    logic        act_low;
    logic        tx_busy;

    // ==========================================================
    // next state
    always_comb begin
        sync1_next   = pin_in;
        sync2_next   = sync1_reg;
        act_low      = ~(sync2_reg ^ cfg.invert);        // RULE10
        lvl_next     = ~act_low;                          // RULE15
        tx_busy      = (tx_cnt_reg != 12'h000);
        low_cnt_next = low_cnt_reg;
        seen_next    = seen_reg;
        rx_next      = 1'b0;
        // own pulse is masked so it never reads back as a received one
        if (!act_low || tx_busy || cfg.func != sync_io_pkg::FUNC_SYNC) begin
            low_cnt_next = 12'h000;
            seen_next    = 1'b0;
        end else if (low_cnt_reg < MIN_LOW) begin
            low_cnt_next = low_cnt_reg + 12'h001;         // RULE14
        end else if (!seen_reg) begin
            seen_next = 1'b1;
            rx_next   = 1'b1;                             // RULE7
        end
        tx_cnt_next = tx_cnt_reg;
        if (cfg.tx_req && cfg.func == sync_io_pkg::FUNC_SYNC) begin
            tx_cnt_next = TX_LEN;
        end else if (tx_busy) begin
            tx_cnt_next = tx_cnt_reg - 12'h001;
        end
        pwm_cnt_next = (pwm_cnt_reg + 16'h0001 >= cfg.pwm_per) ? 16'h0000
                     : pwm_cnt_reg + 16'h0001;
        out_next = 1'b1 ^ cfg.invert;
        oe_next  = 1'b0;
        unique case (cfg.func)
            sync_io_pkg::FUNC_SYNC: begin
                oe_next  = tx_busy;
                out_next = cfg.invert;                    // RULE10
            end
            sync_io_pkg::FUNC_OUTPUT: begin
                oe_next = 1'b1;
                unique case (cfg.out_sel)
                    sync_io_pkg::OUT_TRUE:  out_next = cfg.invert;    // RULE9
                    sync_io_pkg::OUT_PWM:   out_next =                // RULE13
                        (pwm_cnt_reg < cfg.pwm_duty) ^ ~cfg.invert;
                    default:                out_next = ~cfg.invert;   // RULE9
                endcase
            end
            default: begin
                oe_next  = 1'b0;
                out_next = 1'b1;
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg   <= 1'b1;
            sync2_reg   <= 1'b1;
            low_cnt_reg <= 12'h000;
            seen_reg    <= 1'b0;
            rx_reg      <= 1'b0;
            // matches the idle-high synchroniser so no false level follows reset
            lvl_reg     <= 1'b1;
            tx_cnt_reg  <= 12'h000;
            pwm_cnt_reg <= 16'h0000;
            out_reg     <= 1'b1;
            oe_reg      <= 1'b0;
        end else begin
            sync1_reg   <= sync1_next;
            sync2_reg   <= sync2_next;
            low_cnt_reg <= low_cnt_next;
            seen_reg    <= seen_next;
            rx_reg      <= rx_next;
            lvl_reg     <= lvl_next;
            tx_cnt_reg  <= tx_cnt_next;
            pwm_cnt_reg <= pwm_cnt_next;
            out_reg     <= out_next;
            oe_reg      <= oe_next;
        end
    end

    assign cfg.rx_pulse = rx_reg;
    assign cfg.level    = lvl_reg;
    assign pin_out      = out_reg;
    assign pin_oe       = oe_reg;

    // ==========================================================
    // checks
    property p_rx_min_low;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(rx_reg) |-> $past(low_cnt_reg) == MIN_LOW;
    endproperty
    a_rx_min_low: assert property (p_rx_min_low) else $error("pulse taken early"); // RULE14

    property p_true_level;
        @(posedge ref_clk) disable iff (!rst_n)
        (cfg.func == sync_io_pkg::FUNC_OUTPUT && cfg.out_sel == sync_io_pkg::OUT_TRUE)
            [*2] |-> pin_oe && pin_out == $past(cfg.invert);
    endproperty
    a_true_level: assert property (p_true_level) else $error("true level wrong"); // RULE9

    property p_false_level;
        @(posedge ref_clk) disable iff (!rst_n)
        (cfg.func == sync_io_pkg::FUNC_OUTPUT && cfg.out_sel == sync_io_pkg::OUT_FALSE)
            [*2] |-> pin_oe && pin_out == !$past(cfg.invert);
    endproperty
    a_false_level: assert property (p_false_level) else $error("false level wrong"); // RULE9

    property p_input_hiz;
        @(posedge ref_clk) disable iff (!rst_n)
        cfg.func == sync_io_pkg::FUNC_INPUT [*2] |-> !pin_oe;
    endproperty
    a_input_hiz: assert property (p_input_hiz) else $error("input line driven"); // RULE15

    property p_level_inv;
        @(posedge ref_clk) disable iff (!rst_n)
        lvl_reg == ($past(sync2_reg) ^ $past(cfg.invert));
    endproperty
    a_level_inv: assert property (p_level_inv) else $error("level polarity wrong"); // RULE10
endmodule
`default_nettype wire

// File: design/load_sync_trigger_io.sv
/*
 * two configurable trigger lines and the load input switch they follow.
 * assumes a plain register port and synchronous pins; open drain lines.
 */
// Decided for this implementation: the address map and strobed register access.
// Operation
// (RULE1) on line pulses whenever the input switch goes from off to on
// (RULE2) on line pulse while switch on changes nothing
// (RULE3) on line pulse while switch off turns the switch on
// (RULE4) off line pulses whenever the input switch goes from on to off
// (RULE5) off line pulse while switch off changes nothing
// (RULE6) off line pulse while switch on turns the switch off
// (RULE7) a sender holds the line low at least 30 us
// (RULE8) off line offers sync, level input and digital output
// (RULE9) output true drives low, false high; invert swaps
// (RULE10) each line has an invert that flips received and driven polarity
// (RULE11) on line defaults to bidirectional turn-on sync
// (RULE12) off line defaults to bidirectional turn-off sync
// (RULE13) output may be pwm with settable period and duty
// (RULE14) inputs are synchronised and need the minimum low width
// (RULE15) level input presents synchronised, inverted level for reading; code inverts it only when the invert bit is set
`timescale 1ns/1ps
`default_nettype none
module load_sync_trigger_io (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // front panel switch requests
    input  wire logic        panel_on,
    input  wire logic        panel_off,
    // load input switch state
    output logic             load_on,
    // turn-on line
    input  wire logic        on_line_in,
    output logic             on_line_out,
    output logic             on_line_oe,
    // turn-off line
    input  wire logic        off_line_in,
    output logic             off_line_out,
    output logic             off_line_oe
);
    sync_line_if on_if ();
    sync_line_if off_if ();

    logic [4:0]  on_cfg_reg, on_cfg_next, off_cfg_reg, off_cfg_next;
    logic [15:0] on_per_reg, on_per_next, on_duty_reg, on_duty_next;
    logic [15:0] off_per_reg, off_per_next, off_duty_reg, off_duty_next;
    logic [15:0] rdata_reg, rdata_next;
    logic        sw_reg, sw_next;
    logic        sw_on_req, sw_off_req;

    // ==========================================================
    // register file and switch
    always_comb begin
        on_cfg_next   = on_cfg_reg;
        off_cfg_next  = off_cfg_reg;
        on_per_next   = on_per_reg;
        on_duty_next  = on_duty_reg;
        off_per_next  = off_per_reg;
        off_duty_next = off_duty_reg;
        sw_on_req     = panel_on;
        sw_off_req    = panel_off;
        if (wr) begin
            unique case (addr)
                sync_io_pkg::ADDR_ON_CFG:       on_cfg_next   = wdata[4:0];
                sync_io_pkg::ADDR_OFF_CFG:      off_cfg_next  = wdata[4:0];
                sync_io_pkg::ADDR_ON_PWM_PER:   on_per_next   = wdata;
                sync_io_pkg::ADDR_ON_PWM_DUTY:  on_duty_next  = wdata;
                sync_io_pkg::ADDR_OFF_PWM_PER:  off_per_next  = wdata;
                sync_io_pkg::ADDR_OFF_PWM_DUTY: off_duty_next = wdata;
                sync_io_pkg::ADDR_SWITCH_CMD: begin
                    sw_on_req  = panel_on | wdata[sync_io_pkg::CMD_ON_BIT];
                    sw_off_req = panel_off | wdata[sync_io_pkg::CMD_OFF_BIT];
                end
                default: ;
            endcase
        end
        // only three functions exist; a fourth code falls back to sync
        if (off_cfg_next[1:0] == 2'h3) begin
            off_cfg_next[1:0] = sync_io_pkg::FUNC_SYNC;   // RULE8
        end
        if (on_cfg_next[1:0] == 2'h3) begin
            on_cfg_next[1:0] = sync_io_pkg::FUNC_SYNC;
        end
        sw_next = sw_reg;
        if (sw_off_req || off_if.rx_pulse) begin
            sw_next = 1'b0;                               // RULE6 RULE5
        end else if (sw_on_req || on_if.rx_pulse) begin
            sw_next = 1'b1;                               // RULE3 RULE2
        end
        rdata_next = 16'h0000;
        if (rd) begin
            unique case (addr)
                sync_io_pkg::ADDR_ON_CFG:       rdata_next = {11'h000, on_cfg_reg};
                sync_io_pkg::ADDR_OFF_CFG:      rdata_next = {11'h000, off_cfg_reg};
                sync_io_pkg::ADDR_ON_PWM_PER:   rdata_next = on_per_reg;
                sync_io_pkg::ADDR_ON_PWM_DUTY:  rdata_next = on_duty_reg;
                sync_io_pkg::ADDR_OFF_PWM_PER:  rdata_next = off_per_reg;
                sync_io_pkg::ADDR_OFF_PWM_DUTY: rdata_next = off_duty_reg;
                sync_io_pkg::ADDR_STATUS:       rdata_next =
                    {13'h0000, off_if.level, on_if.level, sw_reg};     // RULE15
                default:                        rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            on_cfg_reg   <= sync_io_pkg::CFG_RESET;       // RULE11
            off_cfg_reg  <= sync_io_pkg::CFG_RESET;       // RULE12
            on_per_reg   <= sync_io_pkg::PWM_PER_RESET;
            on_duty_reg  <= sync_io_pkg::PWM_DUTY_RESET;
            off_per_reg  <= sync_io_pkg::PWM_PER_RESET;
            off_duty_reg <= sync_io_pkg::PWM_DUTY_RESET;
            rdata_reg    <= 16'h0000;
            sw_reg       <= 1'b0;
        end else begin
            on_cfg_reg   <= on_cfg_next;
            off_cfg_reg  <= off_cfg_next;
            on_per_reg   <= on_per_next;
            on_duty_reg  <= on_duty_next;
            off_per_reg  <= off_per_next;
            off_duty_reg <= off_duty_next;
            rdata_reg    <= rdata_next;
            sw_reg       <= sw_next;
        end
    end

    // ==========================================================
    // line engines
    assign on_if.func      = on_cfg_reg[1:0];
    assign on_if.invert    = on_cfg_reg[sync_io_pkg::CFG_INV_BIT];
    assign on_if.out_sel   = on_cfg_reg[4:3];
    assign on_if.pwm_per   = on_per_reg;
    assign on_if.pwm_duty  = on_duty_reg;
    assign on_if.tx_req    = sw_next & ~sw_reg;           // RULE1
    assign off_if.func     = off_cfg_reg[1:0];
    assign off_if.invert   = off_cfg_reg[sync_io_pkg::CFG_INV_BIT];
    assign off_if.out_sel  = off_cfg_reg[4:3];
    assign off_if.pwm_per  = off_per_reg;
    assign off_if.pwm_duty = off_duty_reg;
    assign off_if.tx_req   = sw_reg & ~sw_next;           // RULE4

    sync_line u_on (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cfg     (on_if.line),
        .pin_in  (on_line_in),
        .pin_out (on_line_out),
        .pin_oe  (on_line_oe)
    );

    sync_line u_off (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cfg     (off_if.line),
        .pin_in  (off_line_in),
        .pin_out (off_line_out),
        .pin_oe  (off_line_oe)
    );

    assign load_on = sw_reg;
    assign rdata   = rdata_reg;

    // ==========================================================
    // checks
    property p_on_pulse;
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(sw_reg) && on_cfg_reg[1:0] == sync_io_pkg::FUNC_SYNC |-> ##1 on_line_oe;
    endproperty
    a_on_pulse: assert property (p_on_pulse) else $error("no turn-on pulse"); // RULE1

    property p_off_pulse;
        @(posedge ref_clk) disable iff (!rst_n)
        $fell(sw_reg) && off_cfg_reg[1:0] == sync_io_pkg::FUNC_SYNC |-> ##1 off_line_oe;
    endproperty
    a_off_pulse: assert property (p_off_pulse) else $error("no turn-off pulse"); // RULE4

    property p_rx_on;
        @(posedge ref_clk) disable iff (!rst_n)
        on_if.rx_pulse && !off_if.rx_pulse && !panel_off && !wr |=> sw_reg;
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("rx on ignored"); // RULE3

    property p_rx_off;
        @(posedge ref_clk) disable iff (!rst_n)
        off_if.rx_pulse |=> !sw_reg;
    endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx off ignored"); // RULE6

    property p_func_legal;
        @(posedge ref_clk) disable iff (!rst_n)
        off_cfg_reg[1:0] != 2'h3;
    endproperty
    a_func_legal: assert property (p_func_legal) else $error("illegal function"); // RULE8
endmodule
`default_nettype wire

// File: bench/sync_peer.sv
/*
 * partner model: the matching trigger line of another instrument.
 * assumes an open drain wire with pull-up, resolved by the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module sync_peer (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // resolved wire and own driver
    input  wire logic line,
    output logic      drv_oe,
    output logic      drv_out
);
    int lo_cnt;
    int seen;
    int last_w;

    initial begin
        drv_oe  = 1'b0;
        drv_out = 1'b1;
    end

    // ==========================================================
    // watch: low phases that the far end drives, with their width
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lo_cnt <= 0;
            seen   <= 0;
            last_w <= 0;
        end else if (!drv_oe && !line) begin
            lo_cnt <= lo_cnt + 1;
        end else if (lo_cnt != 0) begin
            seen   <= seen + 1;
            last_w <= lo_cnt;
            lo_cnt <= 0;
        end
    end

    // ==========================================================
    // send: hold the line low for w cycles, then release to pull-up
    task automatic send(input int w);
        @(posedge ref_clk);
        drv_oe  <= 1'b1;
        drv_out <= 1'b0;
        repeat (w) @(posedge ref_clk);
        drv_oe  <= 1'b0;
        drv_out <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: bench/load_sync_trigger_io_test.sv
/*
 * self-checking bench for the two trigger lines and the load switch.
 * assumes the register map and timing of sync_io_pkg; peers on both lines.
 */
`timescale 1ns/1ps
`default_nettype none
module load_sync_trigger_io_test;
    logic        ref_clk = 1'b0;
    logic        rst_n;
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        panel_on;
    logic        panel_off;
    logic        load_on;
    logic        on_line_out, on_line_oe, on_drv_oe, on_drv_out, on_wire;
    logic        off_line_out, off_line_oe, off_drv_oe, off_drv_out, off_wire;
    logic [15:0] w;
    int          bad_count = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          lows;

    always #12.5 ref_clk = ~ref_clk;

    // design end has priority; released wire rests at the pull-up
    assign on_wire  = on_line_oe ? on_line_out : (on_drv_oe ? on_drv_out : 1'b1);
    assign off_wire = off_line_oe ? off_line_out : (off_drv_oe ? off_drv_out : 1'b1);

    load_sync_trigger_io i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .panel_on(panel_on), .panel_off(panel_off),
        .load_on(load_on), .on_line_in(on_wire), .on_line_out(on_line_out),
        .on_line_oe(on_line_oe), .off_line_in(off_wire), .off_line_out(off_line_out),
        .off_line_oe(off_line_oe)
    );
    sync_peer i_on_peer (.ref_clk(ref_clk), .rst_n(rst_n), .line(on_wire),
                         .drv_oe(on_drv_oe), .drv_out(on_drv_out));
    sync_peer i_off_peer (.ref_clk(ref_clk), .rst_n(rst_n), .line(off_wire),
                          .drv_oe(off_drv_oe), .drv_out(off_drv_out));

    // ==========================================================
    // access and compare tasks
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // data stand in the cycle after the strobe only
    task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        addr <= a; rd <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic pulse(input logic sel_off);
        @(posedge ref_clk);
        if (sel_off) panel_off <= 1'b1; else panel_on <= 1'b1;
        @(posedge ref_clk);
        panel_off <= 1'b0; panel_on <= 1'b0;
    endtask
    task automatic chk_bit(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_cnt(input string nm, input int e, input int g);
        n_compared++;
        if (g != e) begin
            bad_count++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // run-away guard, well above the sum of the pulse times below
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            final_report();
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        rst_n <= 1'b0;
        addr <= 4'h0;
        wdata <= 16'h0000;
        wr <= 1'b0;
        rd <= 1'b0;
        panel_on <= 1'b0;
        panel_off <= 1'b0;
        wait_n(4);
        rst_n <= 1'b1;
        reg_rd(sync_io_pkg::ADDR_ON_CFG, w);   chk_word("on cfg", 16'h0000, w);
        reg_rd(sync_io_pkg::ADDR_OFF_CFG, w);  chk_word("off cfg", 16'h0000, w);
        reg_rd(sync_io_pkg::ADDR_STATUS, w);   chk_word("status", 16'h0006, w);
        reg_rd(4'hf, w);                       chk_word("unmapped", 16'h0000, w);
        chk_bit("on oe idle", 1'b0, on_line_oe);
        // local switch on: pulse out on the on line only
        pulse(1'b0);
        wait_n(3);                chk_bit("load on", 1'b1, load_on);
        wait_n(1700);
        chk_cnt("on tx count", 1, i_on_peer.seen);
        chk_cnt("on tx width", sync_io_pkg::TX_PULSE_CYC, i_on_peer.last_w);
        chk_cnt("off tx quiet", 0, i_off_peer.seen);
        i_on_peer.send(1210);
        wait_n(50);               chk_bit("on rx while on", 1'b1, load_on);
        chk_cnt("no echo", 1, i_on_peer.seen);
        // local switch off: pulse out on the off line
        pulse(1'b1);
        wait_n(3);                chk_bit("load off", 1'b0, load_on);
        wait_n(1700);
        chk_cnt("off tx count", 1, i_off_peer.seen);
        chk_cnt("off tx width", sync_io_pkg::TX_PULSE_CYC, i_off_peer.last_w);
        i_off_peer.send(1210);
        wait_n(50);               chk_bit("off rx while off", 1'b0, load_on);
        // a low just short of the minimum is a glitch
        i_on_peer.send(1190);
        wait_n(50);               chk_bit("short rx", 1'b0, load_on);
        i_on_peer.send(1210);
        wait_n(50);               chk_bit("on rx while off", 1'b1, load_on);
        wait_n(1700);
        i_off_peer.send(1210);
        wait_n(50);               chk_bit("off rx while on", 1'b0, load_on);
        wait_n(1700);
        // output true/false, plain and inverted, on the off line
        for (int i = 0; i < 4; i++) begin
            reg_wr(sync_io_pkg::ADDR_OFF_CFG,
                   {11'h000, (i[0] ? sync_io_pkg::OUT_TRUE : sync_io_pkg::OUT_FALSE),
                    i[1], sync_io_pkg::FUNC_OUTPUT});
            wait_n(5);
            chk_bit("out oe", 1'b1, off_line_oe);
            chk_bit("out level", i[0] ? i[1] : !i[1], off_line_out);
        end
        // level input, plain then inverted
        reg_wr(sync_io_pkg::ADDR_OFF_CFG, {14'h0000, sync_io_pkg::FUNC_INPUT});
        wait_n(5);                chk_bit("in oe", 1'b0, off_line_oe);
        fork
            i_off_peer.send(40);
            begin
                wait_n(20);
                reg_rd(sync_io_pkg::ADDR_STATUS, w);
                chk_bit("in low", 1'b0, w[sync_io_pkg::ST_LVL_OFF_BIT]);
            end
        join
        reg_wr(sync_io_pkg::ADDR_OFF_CFG, {13'h0000, 1'b1, sync_io_pkg::FUNC_INPUT});
        wait_n(10);
        reg_rd(sync_io_pkg::ADDR_STATUS, w);
        chk_bit("in inv", 1'b0, w[sync_io_pkg::ST_LVL_OFF_BIT]);
        // pwm on the on line: 3 low cycles in every 10
        reg_wr(sync_io_pkg::ADDR_ON_PWM_PER, 16'h000a);
        reg_wr(sync_io_pkg::ADDR_ON_PWM_DUTY, 16'h0003);
        reg_wr(sync_io_pkg::ADDR_ON_CFG, {11'h000, sync_io_pkg::OUT_PWM, 1'b0,
                                          sync_io_pkg::FUNC_OUTPUT});
        wait_n(20);
        lows = 0;
        repeat (100) begin
            @(posedge ref_clk);
            #1 if (on_line_out === 1'b0) lows++;
        end
        chk_cnt("pwm low cycles", 30, lows);
        // command register; off wins when both are set
        reg_wr(sync_io_pkg::ADDR_SWITCH_CMD, 16'h0001);
        wait_n(3);                chk_bit("cmd on", 1'b1, load_on);
        reg_wr(sync_io_pkg::ADDR_SWITCH_CMD, 16'h0003);
        wait_n(3);                chk_bit("cmd both", 1'b0, load_on);
        // mid-run reset puts back the defaults
        reg_wr(sync_io_pkg::ADDR_SWITCH_CMD, 16'h0001);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        wait_n(2);
        rst_n <= 1'b1;
        chk_bit("reset load", 1'b0, load_on);
        reg_rd(sync_io_pkg::ADDR_ON_CFG, w);   chk_word("on cfg again", 16'h0000, w);
        reg_rd(sync_io_pkg::ADDR_STATUS, w);   chk_word("status again", 16'h0006, w);
        final_report();
    end
endmodule
`default_nettype wire
